// ===== logic/tca_fifo.sv
// Data FIFO between the read and write phases of a transfer.
`timescale 1ns/1ps
module tca_fifo #(
  parameter int WIDTH = tca_pkg::FIFO_WIDTH,
  parameter int DEPTH = tca_pkg::FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // Handshakes on both sides; full and empty come from the fill count.
  assign in_ready_o = (count_reg != FULL);
  assign out_valid_o = (count_reg != '0);
  assign out_data_o = mem[rd_ptr_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Storage array, written only on an accepted push.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  // Pointers and fill count.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// ===== logic/tca_pkg.sv
// Shared constants for the transfer controller activation and normal-mode engine.
package tca_pkg;
  localparam int NSRC = 21;
  localparam logic [23:0] VEC_BASE = 24'h000400;
  localparam logic [7:0] RAM_PAGE = 8'hFF;
  localparam logic [23:0] DESC_STRIDE = 24'h00000C;
  localparam logic [2:0] DESC_LAST = 3'h5;
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 8;
  // Mode word A fields.
  localparam int MA_SRC_MODE = 6;
  localparam int MA_DST_MODE = 4;
  localparam int MA_SIZE = 0;
  // Mode word B fields.
  localparam int MB_CHAIN = 7;
  localparam int MB_INTERRUPT_EACH_TRANSFER_SELECT = 6;
  localparam logic [1:0] ADDR_INC = 2'h2;
  localparam logic [1:0] ADDR_DEC = 2'h3;
  localparam int VEC_ENABLE = 7;
  localparam logic [31:0] EN_RESET = 32'h00000000;
  localparam logic [7:0] VEC_RESET = 8'h00;
  // Vector numbers of the hardware sources, highest priority first.
  localparam logic [6:0] SRC_VEC [0:NSRC-1] = '{
    7'h10, 7'h11, 7'h12, 7'h13, 7'h1C, 7'h30, 7'h31, 7'h34, 7'h36, 7'h40, 7'h41,
    7'h44, 7'h45, 7'h48, 7'h49, 7'h51, 7'h52, 7'h55, 7'h56, 7'h5C, 7'h5E};
  // Enable bit index of each source: A7 is bit 31, D0 is bit 0.
  localparam logic [4:0] SRC_EN [0:NSRC-1] = '{
    5'h1F, 5'h1E, 5'h1D, 5'h1C, 5'h1B, 5'h1A, 5'h19, 5'h18, 5'h17, 5'h12, 5'h11,
    5'h10, 5'h0F, 5'h0E, 5'h0D, 5'h0A, 5'h09, 5'h08, 5'h07, 5'h04, 5'h03};
endpackage

// ===== logic/tca_transfer_ctrl.sv
// Transfer controller: activation routing, vector fetch, normal-mode transfer.
//
// Overview of operation
// - Enable bit 1 routes request here, 0 CPU.
// - Start on routed request or vector write.
// - Software run, no interrupt, count left: clear enable.
// - Software run otherwise: keep enable, interrupt CPU.
// - Hardware run, no interrupt, count left: keep enable, clear flag.
// - Hardware run otherwise: clear enable, pass interrupt.
// - Flag updates only after last chained transfer.
// - Routed requests ignore CPU mask and priorities.
// - Fixed priority, software first, last source lowest.
// - Software vector address is base plus field shifted.
// - Read vector, then descriptor from that start.
// - Vector entry is two bytes, RAM low bits.
// - Converter end source uses vector 28, bit A3.
// - Serial 0 receive uses vector 81, bit C2.
// - Descriptor order: modeA, source, modeB, dest, counts.
// - Normal mode moves one byte or word.
// - Count spans 1 to 65536, then interrupt.
// - Count word A counts, count word B ignored.
// - 24-bit addresses step up, down or stay.
// - Updated descriptor is written back to memory.
// - Enable write 1 always, 0 after reading 1.
// - Chain bit set runs next descriptor too.
`timescale 1ns/1ps
module tca_transfer_ctrl (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [20:0] irq_src_i,
  input wire logic en_wr_i,
  input wire logic [31:0] en_wdata_i,
  input wire logic vec_wr_i,
  input wire logic [7:0] vec_wdata_i,
  input wire logic vec_rd_i,
  output logic [31:0] transfer_enable_o,
  output logic [7:0] soft_vector_o,
  output logic [20:0] cpu_irq_o,
  output logic soft_cpu_irq_o,
  output logic [20:0] src_flag_clr_o,
  output logic busy_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic mem_word_o,
  output logic [23:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i
);
  typedef enum logic [2:0] {
    S_IDLE, S_VEC, S_DESC, S_DRD, S_DWR, S_WB, S_DONE, S_SETTLE
  } tca_state_t;
  tca_state_t state_reg;
  logic [31:0] en_reg;
  logic [7:0] vec_reg, mode_a_reg, mode_b_reg;
  logic sw_pend_reg, read_armed_reg, is_sw_reg, ended_reg, req_reg, we_reg, word_reg;
  logic soft_irq_reg, busy_reg, interrupt_each_transfer_select, stop_here, done_w;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [23:0] src_reg, dst_reg, desc_base_reg, addr_reg, sw_vec_addr_w;
  logic [15:0] cnt_a_reg, cnt_b_reg, wdata_reg, wb_half, fifo_out_data;
  logic [2:0] idx_reg;
  logic [4:0] src_idx_reg, pick_idx, en_idx_w;
  logic [20:0] cpu_irq_reg, clr_reg, route_mask, pending, onehot_w;
  // Vector table address for a vector number.
  function automatic logic [23:0] vec_addr(input logic [6:0] num);
    return tca_pkg::VEC_BASE + {16'h0000, num, 1'b0};
  endfunction
  // Address step after a transfer: up, down or fixed by the mode field.
  function automatic logic [23:0] step_addr(input logic [23:0] a, input logic [1:0] m,
                                            input logic w);
    logic [23:0] d;
    d = w ? 24'h000002 : 24'h000001;
    if (m == tca_pkg::ADDR_INC) begin
      return a + d;
    end else if (m == tca_pkg::ADDR_DEC) begin
      return a - d;
    end
    return a;
  endfunction
  // Lowest source index wins among the pending requests.
  function automatic logic [4:0] pick(input logic [20:0] p);
    logic [4:0] r;
    r = 5'h00;
    for (int i = tca_pkg::NSRC - 1; i >= 0; i--) begin
      if (p[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction
  // Routing mask per source and requests that may start the engine.
  always_comb begin
    for (int i = 0; i < tca_pkg::NSRC; i++) begin
      route_mask[i] = en_reg[tca_pkg::SRC_EN[i]];
    end
    pending = irq_src_i & route_mask;
    pick_idx = pick(pending);
  end
  // Descriptor halfword for write-back, in memory order.
  always_comb begin
    unique case (idx_reg)
      3'h0: wb_half = {mode_a_reg, src_reg[23:16]};
      3'h1: wb_half = src_reg[15:0];
      3'h2: wb_half = {mode_b_reg, dst_reg[23:16]};
      3'h3: wb_half = dst_reg[15:0];
      3'h4: wb_half = cnt_a_reg;
      default: wb_half = cnt_b_reg;
    endcase
  end
  assign interrupt_each_transfer_select = mode_b_reg[tca_pkg::MB_INTERRUPT_EACH_TRANSFER_SELECT];
  assign stop_here = interrupt_each_transfer_select || ended_reg;
  assign en_idx_w = tca_pkg::SRC_EN[src_idx_reg];
  assign onehot_w = 21'h000001 << src_idx_reg;
  assign done_w = (state_reg == S_DONE);
  assign sw_vec_addr_w = vec_addr(vec_reg[6:0]);
  assign fifo_in_valid = (state_reg == S_DRD) && req_reg && mem_ack_i;
  assign fifo_out_ready = (state_reg == S_DWR) && !req_reg && fifo_out_valid;
  tca_fifo #(.WIDTH(tca_pkg::FIFO_WIDTH), .DEPTH(tca_pkg::FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i), .srst_i(srst_i), .in_valid_i(fifo_in_valid), .in_ready_o(fifo_in_ready),
    .in_data_i(mem_rdata_i), .out_valid_o(fifo_out_valid), .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data));
  // Sequencer: vector read, descriptor read, data move, write-back, chaining.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= S_IDLE;
      req_reg <= 1'b0;
      we_reg <= 1'b0;
      word_reg <= 1'b0;
      addr_reg <= 24'h000000;
      wdata_reg <= 16'h0000;
      idx_reg <= 3'h0;
      is_sw_reg <= 1'b0;
      src_idx_reg <= 5'h00;
      desc_base_reg <= 24'h000000;
      mode_a_reg <= 8'h00;
      mode_b_reg <= 8'h00;
      src_reg <= 24'h000000;
      dst_reg <= 24'h000000;
      cnt_a_reg <= 16'h0000;
      cnt_b_reg <= 16'h0000;
      ended_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (sw_pend_reg || (|pending)) begin
            is_sw_reg <= sw_pend_reg;
            src_idx_reg <= pick_idx;
            addr_reg <= sw_pend_reg ? sw_vec_addr_w : vec_addr(tca_pkg::SRC_VEC[pick_idx]);
            req_reg <= 1'b1;
            we_reg <= 1'b0;
            word_reg <= 1'b1;
            state_reg <= S_VEC;
          end
        end
        S_VEC: begin
          if (mem_ack_i) begin
            desc_base_reg <= {tca_pkg::RAM_PAGE, mem_rdata_i};
            addr_reg <= {tca_pkg::RAM_PAGE, mem_rdata_i};
            idx_reg <= 3'h0;
            state_reg <= S_DESC;
          end
        end
        S_DESC: begin
          if (mem_ack_i) begin
            unique case (idx_reg)
              3'h0: {mode_a_reg, src_reg[23:16]} <= mem_rdata_i;
              3'h1: src_reg[15:0] <= mem_rdata_i;
              3'h2: {mode_b_reg, dst_reg[23:16]} <= mem_rdata_i;
              3'h3: dst_reg[15:0] <= mem_rdata_i;
              3'h4: cnt_a_reg <= mem_rdata_i;
              default: cnt_b_reg <= mem_rdata_i;
            endcase
            addr_reg <= addr_reg + 24'h000002;
            idx_reg <= idx_reg + 3'h1;
            if (idx_reg == tca_pkg::DESC_LAST) begin
              req_reg <= 1'b0;
              state_reg <= S_DRD;
            end
          end
        end
        S_DRD: begin
          if (!req_reg && fifo_in_ready) begin
            req_reg <= 1'b1;
            we_reg <= 1'b0;
            word_reg <= mode_a_reg[tca_pkg::MA_SIZE];
            addr_reg <= src_reg;
          end else if (req_reg && mem_ack_i) begin
            req_reg <= 1'b0;
            state_reg <= S_DWR;
          end
        end
        S_DWR: begin
          if (fifo_out_ready) begin
            req_reg <= 1'b1;
            we_reg <= 1'b1;
            addr_reg <= dst_reg;
            wdata_reg <= fifo_out_data;
          end else if (req_reg && mem_ack_i) begin
            req_reg <= 1'b0;
            src_reg <= step_addr(src_reg, mode_a_reg[tca_pkg::MA_SRC_MODE +: 2], word_reg);
            dst_reg <= step_addr(dst_reg, mode_a_reg[tca_pkg::MA_DST_MODE +: 2], word_reg);
            cnt_a_reg <= cnt_a_reg - 16'h0001;
            ended_reg <= (cnt_a_reg == 16'h0001);
            idx_reg <= 3'h0;
            state_reg <= S_WB;
          end
        end
        S_WB: begin
          if (!req_reg) begin
            req_reg <= 1'b1;
            we_reg <= 1'b1;
            word_reg <= 1'b1;
            addr_reg <= desc_base_reg + {20'h00000, idx_reg, 1'b0};
            wdata_reg <= wb_half;
          end else if (mem_ack_i) begin
            req_reg <= 1'b0;
            idx_reg <= idx_reg + 3'h1;
            if (idx_reg == tca_pkg::DESC_LAST) begin
              if (mode_b_reg[tca_pkg::MB_CHAIN]) begin
                desc_base_reg <= desc_base_reg + tca_pkg::DESC_STRIDE;
                addr_reg <= desc_base_reg + tca_pkg::DESC_STRIDE;
                idx_reg <= 3'h0;
                req_reg <= 1'b1;
                we_reg <= 1'b0;
                state_reg <= S_DESC;
              end else begin
                state_reg <= S_DONE;
              end
            end
          end
        end
        S_DONE: begin
          state_reg <= S_SETTLE;
        end
        S_SETTLE: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
  // Per-source enable bits; a software write wins over the hardware clear.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      en_reg <= tca_pkg::EN_RESET;
    end else if (en_wr_i) begin
      en_reg <= en_wdata_i;
    end else if (done_w && !is_sw_reg && stop_here) begin
      en_reg[en_idx_w] <= 1'b0;
    end
  end
  // Software vector and its enable; a write of 0 clears it only after a read of 1.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      vec_reg <= tca_pkg::VEC_RESET;
      sw_pend_reg <= 1'b0;
      read_armed_reg <= 1'b0;
    end else begin
      if (vec_rd_i) begin
        read_armed_reg <= vec_reg[tca_pkg::VEC_ENABLE];
      end
      if (state_reg == S_IDLE && sw_pend_reg) begin
        sw_pend_reg <= 1'b0;
      end
      if (done_w && is_sw_reg && !stop_here) begin
        vec_reg[tca_pkg::VEC_ENABLE] <= 1'b0;
      end
      if (vec_wr_i) begin
        vec_reg[6:0] <= vec_wdata_i[6:0];
        read_armed_reg <= 1'b0;
        if (vec_wdata_i[tca_pkg::VEC_ENABLE]) begin
          vec_reg[tca_pkg::VEC_ENABLE] <= 1'b1;
          sw_pend_reg <= 1'b1;
        end else if (read_armed_reg) begin
          vec_reg[tca_pkg::VEC_ENABLE] <= 1'b0;
        end
      end
    end
  end
  // Registered outputs toward the CPU and the interrupt sources.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cpu_irq_reg <= 21'h000000;
      soft_irq_reg <= 1'b0;
      clr_reg <= 21'h000000;
      busy_reg <= 1'b0;
    end else begin
      cpu_irq_reg <= irq_src_i & ~route_mask;
      soft_irq_reg <= done_w && is_sw_reg && stop_here;
      clr_reg <= (done_w && !is_sw_reg && !stop_here) ? onehot_w : 21'h000000;
      busy_reg <= (state_reg != S_IDLE);
    end
  end
  assign transfer_enable_o = en_reg;
  assign soft_vector_o = vec_reg;
  assign cpu_irq_o = cpu_irq_reg;
  assign soft_cpu_irq_o = soft_irq_reg;
  assign src_flag_clr_o = clr_reg;
  assign busy_o = busy_reg;
  assign mem_req_o = req_reg;
  assign mem_we_o = we_reg;
  assign mem_word_o = word_reg;
  assign mem_addr_o = addr_reg;
  assign mem_wdata_o = wdata_reg;

  sequence s_sw_start;
    (state_reg == S_IDLE) && sw_pend_reg;
  endsequence
  sequence s_vec_ack;
    (state_reg == S_VEC) && mem_ack_i;
  endsequence
  sequence s_data_write_ack;
    (state_reg == S_DWR) && req_reg && mem_ack_i;
  endsequence
  property p_route;
    @(posedge clk_i) disable iff (srst_i)
    !$past(srst_i) |-> cpu_irq_o == $past(irq_src_i & ~route_mask);
  endproperty
  a_route: assert property (p_route) else $error("CPU routing wrong");
  property p_sw_clear;
    @(posedge clk_i) disable iff (srst_i)
    (done_w && is_sw_reg && !stop_here && !vec_wr_i) |=>
      !soft_vector_o[7] && !soft_cpu_irq_o;
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("Soft enable not cleared");
  property p_sw_hold;
    @(posedge clk_i) disable iff (srst_i)
    (done_w && is_sw_reg && stop_here && soft_vector_o[7] && !vec_wr_i) |=>
      soft_vector_o[7] && soft_cpu_irq_o ##1 !soft_cpu_irq_o;
  endproperty
  a_sw_hold: assert property (p_sw_hold) else $error("Soft end not signalled");
  property p_hw_keep;
    @(posedge clk_i) disable iff (srst_i)
    (done_w && !is_sw_reg && !stop_here && !en_wr_i) |=>
      src_flag_clr_o == $past(onehot_w) && transfer_enable_o == $past(en_reg);
  endproperty
  a_hw_keep: assert property (p_hw_keep) else $error("Source flag not cleared");
  property p_hw_stop;
    @(posedge clk_i) disable iff (srst_i)
    (done_w && !is_sw_reg && stop_here && !en_wr_i) |=>
      !transfer_enable_o[$past(en_idx_w)] && src_flag_clr_o == 21'h000000;
  endproperty
  a_hw_stop: assert property (p_hw_stop) else $error("Enable bit not cleared");
  property p_end_only;
    @(posedge clk_i) disable iff (srst_i)
    (soft_cpu_irq_o || (src_flag_clr_o != 21'h000000)) |-> $past(done_w);
  endproperty
  a_end_only: assert property (p_end_only) else $error("Update before chain end");
  property p_sw_vector;
    @(posedge clk_i) disable iff (srst_i)
    s_sw_start |=> mem_req_o && !mem_we_o && mem_addr_o == $past(sw_vec_addr_w);
  endproperty
  a_sw_vector: assert property (p_sw_vector) else $error("Soft vector address wrong");
  property p_desc_follow;
    @(posedge clk_i) disable iff (srst_i)
    s_vec_ack |=> (state_reg == S_DESC) && mem_req_o &&
      mem_addr_o == {8'hFF, $past(mem_rdata_i)};
  endproperty
  a_desc_follow: assert property (p_desc_follow) else $error("Descriptor fetch wrong");
  property p_count;
    @(posedge clk_i) disable iff (srst_i)
    s_data_write_ack |=> cnt_a_reg == $past(cnt_a_reg) - 16'h0001 && (state_reg == S_WB);
  endproperty
  a_count: assert property (p_count) else $error("Count not decremented");
endmodule

// ===== sim/tca_mem_model.sv
// Behavioural on-chip RAM and bus partner with adjustable wait states.
`timescale 1ns/1ps
module tca_mem_model (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic mem_word_i,
  input wire logic [23:0] mem_addr_i,
  input wire logic [15:0] mem_wdata_i,
  input wire logic [3:0] wait_i,
  output logic mem_ack_o,
  output logic [15:0] mem_rdata_o
);
  logic [7:0] mem [0:65535];
  logic [3:0] wait_reg;
  logic [15:0] lo;
  assign lo = mem_addr_i[15:0];
  // Acks after wait_i cycles; read data toggles so it is useless away from the ack.
  always @(posedge clk_i) begin
    if (srst_i) begin
      mem_ack_o <= 1'b0;
      wait_reg <= 4'h0;
      mem_rdata_o <= 16'h0000;
    end else if (mem_ack_o || !mem_req_i || wait_reg < wait_i) begin
      mem_ack_o <= 1'b0;
      wait_reg <= (mem_req_i && !mem_ack_o) ? wait_reg + 4'h1 : 4'h0;
      mem_rdata_o <= ~mem_rdata_o;
    end else begin
      mem_ack_o <= 1'b1;
      wait_reg <= 4'h0;
      if (mem_we_i && mem_word_i) begin
        mem[lo] <= mem_wdata_i[15:8];
        mem[lo + 16'h0001] <= mem_wdata_i[7:0];
      end else if (mem_we_i) begin
        mem[lo] <= mem_wdata_i[7:0];
      end else if (mem_word_i) begin
        mem_rdata_o <= {mem[lo], mem[lo + 16'h0001]};
      end else begin
        mem_rdata_o <= {~mem[lo], mem[lo]};
      end
    end
  end
endmodule

// ===== sim/tca_transfer_ctrl_tb.sv
// Self-checking bench for activation, vector fetch and normal-mode transfers.
`timescale 1ns/1ps
module tca_transfer_ctrl_tb;
  logic clk_i;
  logic srst_i = 1'b1;
  logic [20:0] flag_reg = 21'h000000;
  logic [20:0] irq_set = 21'h000000;
  logic [20:0] irq_clr = 21'h000000;
  logic en_wr = 1'b0, vec_wr = 1'b0, vec_rd = 1'b0, mon_clr = 1'b0;
  logic [31:0] en_wd = 32'h0, en_o;
  logic [7:0] vec_wd = 8'h00, vec_o;
  logic [20:0] cpu_o, clr_o, clr_seen;
  logic sirq, soft_seen, busy, req, we, wrd, ack;
  logic [23:0] addr;
  logic [15:0] wd, rd;
  logic [3:0] wait_n = 4'h0;
  logic [15:0] vec_q[$];
  int n_acc, n_errors = 0, num_checks = 0;

  tca_transfer_ctrl i_tca_transfer_ctrl (
    .clk_i(clk_i), .srst_i(srst_i), .irq_src_i(flag_reg), .en_wr_i(en_wr),
    .en_wdata_i(en_wd), .vec_wr_i(vec_wr), .vec_wdata_i(vec_wd), .vec_rd_i(vec_rd),
    .transfer_enable_o(en_o), .soft_vector_o(vec_o), .cpu_irq_o(cpu_o),
    .soft_cpu_irq_o(sirq), .src_flag_clr_o(clr_o), .busy_o(busy), .mem_req_o(req),
    .mem_we_o(we), .mem_word_o(wrd), .mem_addr_o(addr), .mem_wdata_o(wd),
    .mem_ack_i(ack), .mem_rdata_i(rd));
  tca_mem_model i_tca_mem_model (
    .clk_i(clk_i), .srst_i(srst_i), .mem_req_i(req), .mem_we_i(we), .mem_word_i(wrd),
    .mem_addr_i(addr), .mem_wdata_i(wd), .wait_i(wait_n), .mem_ack_o(ack),
    .mem_rdata_o(rd));

  // Free-running 100 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Each source drops its flag at the edge that samples its clear pulse.
  always @(posedge clk_i) flag_reg <= (flag_reg & ~clr_o & ~irq_clr) | irq_set;

  // Records accesses, vector fetches and completion pulses of each run.
  always @(posedge clk_i) begin
    if (mon_clr) begin
      n_acc <= 0;
      clr_seen <= 21'h000000;
      soft_seen <= 1'b0;
      vec_q.delete();
    end else begin
      if (req && ack) n_acc <= n_acc + 1;
      if (req && ack && addr[23:8] == 16'h0004) vec_q.push_back(addr[15:0]);
      clr_seen <= clr_seen | clr_o;
      if (sirq) soft_seen <= 1'b1;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic put16(input logic [15:0] a, input logic [15:0] v);
    i_tca_mem_model.mem[a] = v[15:8];
    i_tca_mem_model.mem[a + 16'h0001] = v[7:0];
  endtask

  function automatic logic [15:0] get16(input logic [15:0] a);
    return {i_tca_mem_model.mem[a], i_tca_mem_model.mem[a + 16'h0001]};
  endfunction

  // Places a vector entry and a descriptor at an aligned start inside the RAM window.
  task automatic put_desc(input logic [15:0] va, st, input logic [7:0] ma,
      input logic [15:0] sa, input logic [7:0] mb, input logic [15:0] da, ca, cb);
    put16(va, st);
    put16(st, {ma, 8'hFF});
    put16(st + 16'h0002, sa);
    put16(st + 16'h0004, {mb, 8'hFF});
    put16(st + 16'h0006, da);
    put16(st + 16'h0008, ca);
    put16(st + 16'h000A, cb);
  endtask

  task automatic set_flags(input logic [20:0] s, input logic [20:0] c);
    @(posedge clk_i);
    irq_set <= s;
    irq_clr <= c;
    @(posedge clk_i);
    irq_set <= 21'h000000;
    irq_clr <= 21'h000000;
  endtask

  task automatic soft_reg(input logic r, input logic w, input logic [7:0] v);
    @(posedge clk_i);
    vec_rd <= r;
    vec_wr <= w;
    vec_wd <= v;
    @(posedge clk_i);
    vec_rd <= 1'b0;
    vec_wr <= 1'b0;
  endtask

  // Writes the enable word and any soft vector together, raises flags, waits for nv runs.
  task automatic run(input logic [20:0] irq, input logic [7:0] vw, input logic [31:0] en,
      input int nv);
    int k;
    k = 0;
    @(posedge clk_i);
    mon_clr <= 1'b1;
    @(posedge clk_i);
    mon_clr <= 1'b0;
    en_wr <= 1'b1;
    en_wd <= en;
    irq_set <= irq;
    vec_wr <= vw[7];
    vec_wd <= vw;
    @(posedge clk_i);
    en_wr <= 1'b0;
    irq_set <= 21'h000000;
    vec_wr <= 1'b0;
    while (k < 3000 && (vec_q.size() < nv || busy !== 1'b0)) begin
      @(negedge clk_i);
      k++;
    end
    if (k == 3000) begin
      check("run completion", 32'h0, 32'h1);
      finish_test();
    end
    tick(3);
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    tick(1);
    check("enable word", 32'h0, en_o);
    check("soft vector", 32'h0, vec_o);
    check("cpu requests", 32'h0, cpu_o);
    // A flag whose enable bit is clear goes to the CPU and starts nothing.
    set_flags(21'h008000, 21'h000000);
    tick(2);
    check("cpu route", 32'h1, cpu_o[15]);
    check("idle", 32'h0, busy);
    set_flags(21'h000000, 21'h008000);
    // Converter-end source, slow memory, count left: enable kept and flag cleared.
    wait_n <= 4'h3;
    put_desc(16'h0438, 16'hEC00, 8'h80, 16'hE010, 8'h00, 16'hE020, 16'h0003, 16'h1234);
    put16(16'hE010, 16'h5A00);
    run(21'h000010, 8'h00, 32'h08000000, 1);
    check("vector addr", 32'h0438, vec_q[0]);
    check("accesses", 32'h0000000F, n_acc);
    check("data byte", 32'h5A, i_tca_mem_model.mem[16'hE020]);
    check("src back", 32'hE011, get16(16'hEC02));
    check("count a", 32'h0002, get16(16'hEC08));
    check("count b", 32'h1234, get16(16'hEC0A));
    check("enable kept", 32'h08000000, en_o);
    check("flag clear", 32'h10, clr_seen);
    check("no cpu irq", 32'h0, cpu_o[4]);
    // Serial 0 receive, word to a falling address, last count: enable cleared, irq passed.
    wait_n <= 4'h0;
    put_desc(16'h04A2, 16'hEC10, 8'h31, 16'hE030, 8'h00, 16'hE040, 16'h0001, 16'h0000);
    put16(16'hE030, 16'hBEEF);
    run(21'h008000, 8'h00, 32'h00000400, 1);
    check("vector addr", 32'h04A2, vec_q[0]);
    check("data word", 32'hBEEF, get16(16'hE040));
    check("dst back", 32'hE03E, get16(16'hEC16));
    check("count a", 32'h0, get16(16'hEC18));
    check("enable off", 32'h0, en_o);
    check("flag held", 32'h0, clr_seen);
    check("cpu irq", 32'h1, cpu_o[15]);
    set_flags(21'h000000, 21'h008000);
    // Soft vector and a pending source enabled together: software goes first.
    set_flags(21'h000010, 21'h000000);
    put_desc(16'h0438, 16'hEC00, 8'h00, 16'hE010, 8'h00, 16'hE022, 16'h0000, 16'h0000);
    put_desc(16'h0420, 16'hEC20, 8'h00, 16'hE010, 8'h00, 16'hE024, 16'h0005, 16'h0000);
    run(21'h000000, 8'h90, 32'h08000000, 2);
    check("first vector", 32'h0420, vec_q[0]);
    check("second vector", 32'h0438, vec_q[1]);
    check("soft data", 32'h5A, i_tca_mem_model.mem[16'hE024]);
    check("soft enable", 32'h10, vec_o);
    check("soft count", 32'h0004, get16(16'hEC28));
    check("max count", 32'hFFFF, get16(16'hEC08));
    check("flag clear", 32'h10, clr_seen);
    // Soft run with interrupt on each transfer, then the read-before-clear rule.
    put_desc(16'h0420, 16'hEC20, 8'h00, 16'hE010, 8'h40, 16'hE024, 16'h0005, 16'h0000);
    run(21'h000000, 8'h90, 32'h00000000, 1);
    check("soft irq", 32'h1, soft_seen);
    check("soft held", 32'h90, vec_o);
    soft_reg(1'b0, 1'b1, 8'h10);
    tick(1);
    check("clear refused", 32'h90, vec_o);
    soft_reg(1'b1, 1'b0, 8'h00);
    soft_reg(1'b0, 1'b1, 8'h10);
    tick(1);
    check("clear taken", 32'h10, vec_o);
    // Two chained descriptors: end actions follow the last one only.
    put_desc(16'h0438, 16'hEC00, 8'h80, 16'hE010, 8'h80, 16'hE026, 16'h0002, 16'h0000);
    put_desc(16'h0000, 16'hEC0C, 8'h00, 16'hE010, 8'h00, 16'hE028, 16'h0001, 16'h0000);
    run(21'h000010, 8'h00, 32'h08000000, 1);
    check("chain accesses", 32'h0000001D, n_acc);
    check("chain data", 32'h5A, i_tca_mem_model.mem[16'hE028]);
    check("chain enable", 32'h0, en_o);
    check("chain flag", 32'h0, clr_seen);
    check("chain irq", 32'h1, cpu_o[4]);
    set_flags(21'h000000, 21'h000010);
    // A reset in mid-run drops the engine and the bus back to idle and clears the enable word and soft vector.
    soft_reg(1'b0, 1'b1, 8'h90);
    tick(4);
    check("busy mid-run", 32'h1, busy);
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    tick(1);
    check("reset busy", 32'h0, busy);
    check("reset request", 32'h0, req);
    check("reset enables", 32'h0, en_o);
    check("reset vector", 32'h0, vec_o);
    finish_test();
  end
endmodule
